/* File: timer8_pkg.sv */
// constants, types and carriers of the 8-bit timer with two compare channels
// assumes a single 25 MHz ref_clk domain and a processor-side port map
package timer8_pkg;

    // ------------------------------------------------------------
    // counter limits and mode codes
    // ------------------------------------------------------------
    localparam logic [7:0] BOTTOM = 8'h00;
    localparam logic [7:0] MAX = 8'hFF;
    localparam logic [2:0] WGM_NORMAL = 3'h0;
    localparam logic [2:0] WGM_CTC = 3'h2;
    localparam int WGM_PWM_BIT = 0;
    localparam int WGM_FAST_BIT = 1;
    localparam int WGM_TOP_A_BIT = 2;
    localparam logic [1:0] ACT_NONE = 2'h0;
    localparam logic [1:0] ACT_TOGGLE = 2'h1;
    localparam logic [1:0] ACT_CLEAR = 2'h2;
    localparam logic [1:0] ACT_SET = 2'h3;
    localparam logic [2:0] CS_STOP = 3'h0;
    localparam logic [0:7][9:0] CS_MASK = '{10'h000, 10'h000, 10'h007, 10'h01F,
                                            10'h03F, 10'h07F, 10'h0FF, 10'h3FF};
    localparam logic PIN_OE_N_RESET = 1'b1;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef enum logic {DIR_UP = 1'b0, DIR_DOWN = 1'b1} count_dir_t;

    typedef struct packed {
        logic [2:0] waveform_mode_field;
        logic [2:0] clock_select_field;
        logic async_clock_select;
        logic counter_wr;
        logic overflow_clear;
        logic overflow_irq_en;
        logic overflow_ack;
    } timer_ctrl_t;

    typedef struct packed {
        logic [1:0] output_action_field;
        logic force_match_strobe;
        logic compare_wr;
        logic flag_clear;
        logic irq_en;
        logic irq_ack;
        logic output_pin_direction;
        logic port_out;
    } chan_ctrl_t;

    typedef struct packed {
        logic [7:0] compare_value_channel;
        logic match_flag_channel;
        logic irq;
        logic pin_out;
        logic pin_oe_n;
    } chan_out_t;

    typedef struct packed {
        logic [7:0] working;
        logic [7:0] buffer;
        logic compare_output_channel;
        logic seen;
        chan_out_t out;
    } chan_state_t;

    typedef struct packed {
        logic [7:0] counter_value;
        count_dir_t dir;
        logic overflow_flag;
        logic overflow_irq;
        logic [9:0] prescale;
        logic osc_s1;
        logic osc_s2;
        logic osc_s3;
        logic block;
        chan_state_t [1:0] ch;
    } timer_state_t;

endpackage

/* File: timer8_counter_compare_unit.sv */
// 8-bit timer/counter with two output compare channels
// assumes processor controls arrive as same-clock levels and one-cycle strobes;
// the oscillator pin is asynchronous and is synchronised here
`timescale 1ns/1ps
`default_nettype none

module timer8_counter_compare_unit (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic osc_pin_one,
    input wire timer8_pkg::timer_ctrl_t timer_ctrl,
    input wire logic [7:0] wr_data,
    input wire timer8_pkg::chan_ctrl_t chan_a_ctrl,
    input wire timer8_pkg::chan_ctrl_t chan_b_ctrl,
    output logic [7:0] counter_value,
    output logic overflow_flag,
    output logic overflow_irq,
    output timer8_pkg::chan_out_t chan_a_out,
    output timer8_pkg::chan_out_t chan_b_out
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // prescaler tap: true when the selected division point is reached
    function automatic logic tap_hit(input logic [2:0] cs, input logic [9:0] pre);
        return (cs != timer8_pkg::CS_STOP) &&
               ((pre & timer8_pkg::CS_MASK[cs]) == timer8_pkg::CS_MASK[cs]);
    endfunction

    // output state after a match; inv flips the clear/set sense
    function automatic logic match_action(input logic [1:0] act, input logic oc,
                                          input logic inv);
        logic r;
        r = oc;
        unique case (act)
            timer8_pkg::ACT_NONE: r = oc;
            timer8_pkg::ACT_TOGGLE: r = ~oc;
            timer8_pkg::ACT_CLEAR: r = inv;
            timer8_pkg::ACT_SET: r = ~inv;
        endcase
        return r;
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    timer8_pkg::timer_state_t st_reg;
    timer8_pkg::timer_state_t st_next;
    timer8_pkg::chan_ctrl_t [1:0] cc;

    // both channels travel as one packed pair, channel a in the low slot
    assign cc = {chan_b_ctrl, chan_a_ctrl};

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic src;
        logic tick;
        logic pwm;
        logic fast;
        logic pc;
        logic [2:0] wgm;
        logic [7:0] top;
        logic at_top;
        logic at_bot;
        logic ovf_set;
        logic reload;
        logic wrap;
        logic [1:0] eq;
        st_next = st_reg;
        // every local starts defined so no path leaves a latch behind
        src = 1'b0;
        tick = 1'b0;
        top = timer8_pkg::MAX;
        at_top = 1'b0;
        at_bot = 1'b0;
        eq = 2'h0;
        wgm = timer_ctrl.waveform_mode_field;
        pwm = wgm[timer8_pkg::WGM_PWM_BIT];
        fast = pwm && wgm[timer8_pkg::WGM_FAST_BIT];
        pc = pwm && !wgm[timer8_pkg::WGM_FAST_BIT];
        ovf_set = 1'b0;
        reload = 1'b0;
        wrap = 1'b0;

        // oscillator pin: three flops, then edge detect on the second and third
        st_next.osc_s1 = osc_pin_one;
        st_next.osc_s2 = st_reg.osc_s1;
        st_next.osc_s3 = st_reg.osc_s2;

        // clock source and prescaler; source defaults to the system clock
        src = timer_ctrl.async_clock_select ?
              (st_reg.osc_s2 && !st_reg.osc_s3) : 1'b1;
        if (src) begin
            st_next.prescale = st_reg.prescale + 10'h001;
        end
        tick = src && tap_hit(timer_ctrl.clock_select_field, st_reg.prescale);

        // top is max or compare value a, depending on mode
        top = (wgm[timer8_pkg::WGM_TOP_A_BIT] || wgm == timer8_pkg::WGM_CTC) ?
              st_reg.ch[0].working : timer8_pkg::MAX;
        at_top = st_reg.counter_value == top;
        at_bot = st_reg.counter_value == timer8_pkg::BOTTOM;

        // comparators run every cycle, ticking or not
        for (int i = 0; i < 2; i++) begin
            eq[i] = st_reg.counter_value == st_reg.ch[i].working;
        end

        // counter sequence per mode
        if (tick) begin
            if (pc) begin
                if (st_reg.dir == timer8_pkg::DIR_UP) begin
                    if (at_top) begin
                        st_next.dir = timer8_pkg::DIR_DOWN;
                        st_next.counter_value = st_reg.counter_value - 8'h01;
                        reload = 1'b1;
                    end else begin
                        st_next.counter_value = st_reg.counter_value + 8'h01;
                    end
                end else begin
                    if (at_bot) begin
                        st_next.dir = timer8_pkg::DIR_UP;
                        st_next.counter_value = st_reg.counter_value + 8'h01;
                        ovf_set = 1'b1;
                    end else begin
                        st_next.counter_value = st_reg.counter_value - 8'h01;
                    end
                end
            end else begin
                st_next.dir = timer8_pkg::DIR_UP;
                if (fast && at_top) begin
                    st_next.counter_value = timer8_pkg::BOTTOM;
                    ovf_set = 1'b1;
                    reload = 1'b1;
                    wrap = 1'b1;
                end else if (wgm == timer8_pkg::WGM_CTC && at_top) begin
                    st_next.counter_value = timer8_pkg::BOTTOM;
                    ovf_set = st_reg.counter_value == timer8_pkg::MAX;
                end else begin
                    // normal and reserved codes count up and wrap at max
                    st_next.counter_value = st_reg.counter_value + 8'h01;
                    ovf_set = st_reg.counter_value == timer8_pkg::MAX;
                end
            end
            st_next.block = 1'b0;
        end

        // channels
        for (int i = 0; i < 2; i++) begin
            if (tick) begin
                // a match seen this tick is acted on at the next one
                st_next.ch[i].seen = eq[i] && !st_reg.block;
                if (st_reg.ch[i].seen) begin
                    st_next.ch[i].out.match_flag_channel = 1'b1;
                    st_next.ch[i].compare_output_channel = match_action(
                        cc[i].output_action_field, st_reg.ch[i].compare_output_channel,
                        pc && st_reg.dir == timer8_pkg::DIR_DOWN);
                end
                // fast pwm: opposite level at bottom for clear/set actions
                if (wrap && cc[i].output_action_field[1]) begin
                    st_next.ch[i].compare_output_channel = ~cc[i].output_action_field[0];
                end
            end
            // forced match: output only, no flag, no counter effect
            if (!pwm && cc[i].force_match_strobe) begin
                st_next.ch[i].compare_output_channel = match_action(
                    cc[i].output_action_field, st_reg.ch[i].compare_output_channel, 1'b0);
            end
            // buffered load at top or bottom
            if (pwm && reload) begin
                st_next.ch[i].working = st_reg.ch[i].buffer;
            end
            // processor compare writes
            if (cc[i].compare_wr) begin
                if (pwm) begin
                    st_next.ch[i].buffer = wr_data;
                end else begin
                    st_next.ch[i].working = wr_data;
                    st_next.ch[i].buffer = wr_data;
                end
            end
            st_next.ch[i].out.compare_value_channel =
                pwm ? st_next.ch[i].buffer : st_next.ch[i].working;
            // flag clear by one-write or service; a same-cycle set wins
            st_next.ch[i].out.match_flag_channel =
                (st_reg.ch[i].out.match_flag_channel &&
                 !(cc[i].flag_clear || cc[i].irq_ack)) ||
                (tick && st_reg.ch[i].seen);
            st_next.ch[i].out.irq =
                st_next.ch[i].out.match_flag_channel && cc[i].irq_en;
            // port override; direction stays with the port bit
            st_next.ch[i].out.pin_out = (cc[i].output_action_field != timer8_pkg::ACT_NONE) ?
                st_next.ch[i].compare_output_channel : cc[i].port_out;
            st_next.ch[i].out.pin_oe_n = !cc[i].output_pin_direction;
        end

        // overflow flag with the same set-wins clearing
        st_next.overflow_flag = (st_reg.overflow_flag &&
            !(timer_ctrl.overflow_clear || timer_ctrl.overflow_ack)) || ovf_set;
        st_next.overflow_irq = st_next.overflow_flag && timer_ctrl.overflow_irq_en;

        // processor counter write last so it overrides count and clear;
        // the block flag then stays up until the next tick, even while stopped
        if (timer_ctrl.counter_wr) begin
            st_next.counter_value = wr_data;
            st_next.block = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // mode changes touch no output state, so it carries across them
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st_reg <= '0;
            st_reg.ch[0].out.pin_oe_n <= timer8_pkg::PIN_OE_N_RESET;
            st_reg.ch[1].out.pin_oe_n <= timer8_pkg::PIN_OE_N_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs straight from the state flops
    assign counter_value = st_reg.counter_value;
    assign overflow_flag = st_reg.overflow_flag;
    assign overflow_irq = st_reg.overflow_irq;
    assign chan_a_out = st_reg.ch[0].out;
    assign chan_b_out = st_reg.ch[1].out;

endmodule

`default_nettype wire

/* File: osc_source.sv */
// oscillator model driving the timer's oscillator pin
// assumes the bench enables it only when the timer takes oscillator ticks
`timescale 1ns/1ps
`default_nettype none
module osc_source (
    input wire logic run_en,
    output logic osc_pin_one
);
    // ----
    // oscillation
    // ----
    // half period off the 40 ns grid so edges drift against ref_clk
    initial begin
        osc_pin_one = 1'b0;
        forever begin
            #70;
            osc_pin_one = run_en ? ~osc_pin_one : 1'b0; // rests low when idle
        end
    end
endmodule
`default_nettype wire

/* File: timer8_properties.sv */
// port-level assertions of the 8-bit timer
// assumes one ref_clk domain with synchronous active-high rst
`timescale 1ns/1ps
`default_nettype none
module timer8_properties (
    input wire logic ref_clk,
    input wire logic rst,
    input wire timer8_pkg::timer_ctrl_t timer_ctrl,
    input wire logic [7:0] wr_data,
    input wire timer8_pkg::chan_ctrl_t chan_a_ctrl,
    input wire logic [7:0] counter_value,
    input wire logic overflow_flag,
    input wire timer8_pkg::chan_out_t chan_a_out
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // ----
    // helper terms and sequences
    // ----
    // undivided system ticks in normal mode, so one tick per cycle
    wire logic run = timer_ctrl.clock_select_field == 3'h1 && !timer_ctrl.async_clock_select
        && timer_ctrl.waveform_mode_field == 3'h0;
    wire logic eq_a = counter_value == chan_a_out.compare_value_channel;
    wire logic flg = chan_a_out.match_flag_channel;
    sequence s_wrap;
        run && !timer_ctrl.counter_wr && counter_value == 8'hFF ##1 counter_value == 8'h00;
    endsequence
    sequence s_match;
        run && !timer_ctrl.counter_wr ##1 run && eq_a && !timer_ctrl.counter_wr ##1 run;
    endsequence
    sequence s_quiet;
        (run && !eq_a && !chan_a_ctrl.compare_wr && !flg)[*4];
    endsequence
    sequence s_armed;
        chan_a_ctrl.irq_en && flg;
    endsequence
    AST_STOP: assert property (timer_ctrl.clock_select_field == 3'h0 && !timer_ctrl.counter_wr
        |=> $stable(counter_value)) else $error("counter moved while stopped");
    AST_WRITE: assert property (timer_ctrl.counter_wr
        |=> counter_value == $past(wr_data)) else $error("counter write lost");
    AST_WRAP: assert property (s_wrap |-> overflow_flag)
        else $error("overflow flag missing at wrap");
    AST_STEP: assert property (run && !timer_ctrl.counter_wr && counter_value != 8'hFF
        |=> counter_value == $past(counter_value) + 8'h01) else $error("count step wrong");
    AST_MATCH: assert property (s_match |-> ##[0:2] flg)
        else $error("match flag missing");
    AST_BLOCK: assert property (s_quiet ##0 (timer_ctrl.counter_wr && wr_data ==
        chan_a_out.compare_value_channel) |=> (!flg)[*3]) else $error("blocked match seen");
    AST_STICKY: assert property (flg && !chan_a_ctrl.flag_clear && !chan_a_ctrl.irq_ack
        |=> flg) else $error("flag dropped");
    AST_IRQ: assert property (s_armed ##1 s_armed |-> chan_a_out.irq)
        else $error("interrupt missing");
    AST_OE: assert property (chan_a_ctrl.output_pin_direction |=> !chan_a_out.pin_oe_n)
        else $error("pin not driven");
    AST_PORT: assert property (chan_a_ctrl.output_action_field == 2'h0
        && chan_a_ctrl.output_pin_direction
        |=> chan_a_out.pin_out == $past(chan_a_ctrl.port_out)) else $error("port value lost");
endmodule
bind timer8_counter_compare_unit timer8_properties chk_u (.ref_clk, .rst, .timer_ctrl,
    .wr_data, .chan_a_ctrl, .counter_value, .overflow_flag, .chan_a_out);
`default_nettype wire

/* File: timer8_counter_compare_unit_tb.sv */
// self-checking bench for the 8-bit timer with two compare channels
// drives processor controls directly; an oscillator model feeds the pin
`timescale 1ns/1ps
`default_nettype none
module timer8_counter_compare_unit_tb;
    logic ref_clk, rst, osc_en, osc_pin, ovf, ovf_irq;
    logic [7:0] wd, cnt, c0;
    timer8_pkg::timer_ctrl_t tc;
    timer8_pkg::chan_ctrl_t ca, cb;
    timer8_pkg::chan_out_t oa, ob;
    int failures, n_compared;
    // ----
    // clock, oscillator model and unit
    // ----
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    osc_source src_u (.run_en(osc_en), .osc_pin_one(osc_pin));
    timer8_counter_compare_unit dut_u (.ref_clk(ref_clk), .rst(rst), .osc_pin_one(osc_pin),
        .timer_ctrl(tc), .wr_data(wd), .chan_a_ctrl(ca), .chan_b_ctrl(cb),
        .counter_value(cnt), .overflow_flag(ovf), .overflow_irq(ovf_irq),
        .chan_a_out(oa), .chan_b_out(ob));
    // ----
    // shared steps; checks sample 1 ns after the edge
    // ----
    task automatic tk(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr_cnt(input logic [7:0] v);
        @(posedge ref_clk);
        tc.counter_wr <= 1'b1;
        wd <= v;
        @(posedge ref_clk);
        tc.counter_wr <= 1'b0;
        #1;
    endtask
    task automatic report_and_stop;
        if (failures == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // ----
    // scenarios
    // ----
    task automatic t_stop;
        wr_cnt(8'h40);
        chk(cnt, 8'h40);
        tk(5);
        chk(cnt, 8'h40);
    endtask
    // wrap from 0xFF with the flag raised in the same cycle
    task automatic t_wrap;
        wr_cnt(8'hFD);
        @(posedge ref_clk);
        tc.clock_select_field <= 3'h1;
        tc.overflow_irq_en <= 1'b1;
        for (int i = 0; i < 12 && ovf !== 1'b1; i++) tk(1);
        chk({7'h00, ovf}, 8'h01);
        chk({7'h00, ovf_irq}, 8'h01);
        chk(cnt, timer8_pkg::BOTTOM);
        tk(1);
        chk(cnt, 8'h01);
        @(posedge ref_clk);
        tc.overflow_clear <= 1'b1;
        @(posedge ref_clk);
        tc.overflow_clear <= 1'b0;
        tk(1);
        chk({7'h00, ovf}, 8'h00);
        chk({7'h00, ovf_irq}, 8'h00);
    endtask
    // stale flag from the wrap past compare 0x00 is cleared first
    task automatic t_match;
        @(posedge ref_clk);
        tc.clock_select_field <= 3'h0;
        ca.compare_wr <= 1'b1;
        ca.flag_clear <= 1'b1;
        ca.irq_en <= 1'b1;
        wd <= 8'h30;
        @(posedge ref_clk);
        ca.compare_wr <= 1'b0;
        ca.flag_clear <= 1'b0;
        tk(1);
        chk(oa.compare_value_channel, 8'h30);
        wr_cnt(8'h2C);
        @(posedge ref_clk);
        tc.clock_select_field <= 3'h1;
        for (int i = 0; i < 12 && oa.match_flag_channel !== 1'b1; i++) tk(1);
        chk({7'h00, oa.match_flag_channel}, 8'h01);
        chk({7'h00, ob.match_flag_channel}, 8'h01);
        chk(cnt, 8'h32);
        tk(1);
        chk({7'h00, oa.irq}, 8'h01);
        @(posedge ref_clk);
        ca.irq_ack <= 1'b1;
        @(posedge ref_clk);
        ca.irq_ack <= 1'b0;
        tk(1);
        chk({7'h00, oa.match_flag_channel}, 8'h00);
        tk(2);
        wr_cnt(8'h30); // counter written equal to compare a on purpose
        tk(4);
        chk({7'h00, oa.match_flag_channel}, 8'h00);
        @(posedge ref_clk);
        tc.clock_select_field <= 3'h0;
    endtask
    task automatic force_chk(input logic [1:0] act, input logic [7:0] exp);
        @(posedge ref_clk);
        ca.output_action_field <= act;
        ca.force_match_strobe <= 1'b1;
        @(posedge ref_clk);
        ca.force_match_strobe <= 1'b0;
        tk(2);
        chk({7'h00, oa.pin_out}, exp);
    endtask
    // port value stays 0, so a high pin can only come from the channel state
    task automatic t_force;
        @(posedge ref_clk);
        ca.output_pin_direction <= 1'b1;
        force_chk(timer8_pkg::ACT_SET, 8'h01);
        chk({7'h00, oa.pin_oe_n}, 8'h00);
        chk({7'h00, ob.pin_oe_n}, 8'h01);
        force_chk(timer8_pkg::ACT_CLEAR, 8'h00);
        force_chk(timer8_pkg::ACT_TOGGLE, 8'h01);
        force_chk(timer8_pkg::ACT_NONE, 8'h00);
        @(posedge ref_clk);
        tc.waveform_mode_field <= 3'h3;
        force_chk(timer8_pkg::ACT_TOGGLE, 8'h01);
        chk({7'h00, oa.match_flag_channel}, 8'h00);
    endtask
    // fast pwm: a new compare value waits in the buffer until the wrap
    task automatic t_pwm;
        @(posedge ref_clk);
        ca.compare_wr <= 1'b1;
        ca.flag_clear <= 1'b1;
        wd <= 8'h10;
        @(posedge ref_clk);
        ca.compare_wr <= 1'b0;
        ca.flag_clear <= 1'b0;
        tk(1);
        chk(oa.compare_value_channel, 8'h10);
        wr_cnt(8'h2E);
        @(posedge ref_clk);
        tc.clock_select_field <= 3'h1;
        for (int i = 0; i < 12 && oa.match_flag_channel !== 1'b1; i++) tk(1);
        chk(cnt, 8'h32);
        @(posedge ref_clk);
        ca.flag_clear <= 1'b1;
        @(posedge ref_clk);
        ca.flag_clear <= 1'b0;
        tk(1);
        for (int i = 0; i < 300 && oa.match_flag_channel !== 1'b1; i++) tk(1);
        chk(cnt, 8'h12);
        @(posedge ref_clk);
        tc.clock_select_field <= 3'h0;
    endtask
    // clear on match at compare a, then one turn at the top in phase correct
    task automatic t_ctc;
        @(posedge ref_clk);
        tc.waveform_mode_field <= timer8_pkg::WGM_CTC;
        ca.compare_wr <= 1'b1;
        ca.flag_clear <= 1'b1;
        wd <= 8'h05;
        @(posedge ref_clk);
        ca.compare_wr <= 1'b0;
        ca.flag_clear <= 1'b0;
        wr_cnt(8'h00);
        @(posedge ref_clk);
        tc.clock_select_field <= 3'h1;
        for (int i = 0; i < 12 && oa.match_flag_channel !== 1'b1; i++) tk(1);
        chk(cnt, 8'h01);
        @(posedge ref_clk);
        tc.clock_select_field <= 3'h0;
        tc.waveform_mode_field <= 3'h1;
        wr_cnt(8'hFE);
        @(posedge ref_clk);
        tc.clock_select_field <= 3'h1;
        tk(3);
        chk(cnt, 8'hFD);
        @(posedge ref_clk);
        tc.clock_select_field <= 3'h0;
    endtask
    task automatic t_async;
        @(posedge ref_clk);
        tc.waveform_mode_field <= 3'h0;
        tc.async_clock_select <= 1'b1;
        tc.clock_select_field <= 3'h1;
        tk(20);
        c0 = cnt;
        tk(20);
        chk(cnt, c0);
        osc_en = 1'b1;
        tk(40);
        chk({7'h00, cnt != c0}, 8'h01);
    endtask
    // ----
    // main sequence and watchdog
    // ----
    initial begin
        tc = '0;
        ca = '0;
        cb = '0;
        wd = 8'h00;
        rst = 1'b1;
        osc_en = 1'b0;
        failures = 0;
        n_compared = 0;
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        tk(1);
        chk(cnt, timer8_pkg::BOTTOM);
        t_stop();
        t_wrap();
        t_match();
        t_force();
        t_pwm();
        t_ctc();
        t_async();
        report_and_stop();
    end
    // about 420 cycles are needed; 2500 leaves ample margin
    initial begin
        #100000;
        failures++;
        report_and_stop();
    end
endmodule
`default_nettype wire
